// >>> sbr_pkg.sv
package sbr_pkg;

    // ****************************************
    // Timing
    // ****************************************
    // Clock rate in kHz, period 20 ns
    localparam int unsigned CLK_KHZ = 50000;
    // Reset pulse interval, ms (nominal and least)
    localparam int unsigned RST_PULSE_MS = 200;
    localparam int unsigned RST_MIN_MS = 140;
    // Cycle counts derived from the clock rate
    localparam int unsigned RST_PULSE_CYC = RST_PULSE_MS * CLK_KHZ;
    localparam int unsigned RST_MIN_CYC = RST_MIN_MS * CLK_KHZ;
    // Counter width, wide enough for the pulse count
    localparam int unsigned CNT_W = 24;
    // Synchroniser depth
    localparam int unsigned SYNC_STAGES = 2;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic RST_OUT_RESET = 1'b0;
    localparam logic BACKUP_RESET = 1'b0;
    localparam logic PFO_RESET = 1'b0;

    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        SBR_HOLD = 3'b001,
        SBR_TIME = 3'b010,
        SBR_RUN = 3'b100
    } sbr_state_t;

endpackage

// >>> sbr_sync_if.sv
`timescale 1ns/1ps
`default_nettype none

// Synchronised comparator levels between the front end and the sequencer
interface sbr_sync_if;
    logic supply_low;
    logic batt_above;
    logic pf_low;
    logic mr_low;
    modport sync (output supply_low, output batt_above, output pf_low, output mr_low);
    modport core (input supply_low, input batt_above, input pf_low, input mr_low);
endinterface

`default_nettype wire

// >>> sbr_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for one asynchronous level
module sbr_sync
    import sbr_pkg::*;
#(
    parameter logic INIT = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Level
    input wire logic d_i,
    output logic q_o
);
    logic [SYNC_STAGES-1:0] stage_q;

    // First stage is read only by the second
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stage_q <= {SYNC_STAGES{INIT}};
        end else begin
            stage_q <= {stage_q[SYNC_STAGES-2:0], d_i};
        end
    end

    assign q_o = stage_q[SYNC_STAGES-1];
endmodule // sbr_sync

`default_nettype wire

// >>> sbr_supervisor.sv
`timescale 1ns/1ps
`default_nettype none

module sbr_supervisor
    import sbr_pkg::*;
#(
    parameter int unsigned PULSE_CYC = RST_PULSE_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Comparator results, asynchronous
    input wire logic supply_low_i,
    input wire logic batt_above_i,
    input wire logic power_fail_in_i,
    input wire logic manual_reset_n_i,
    // Outputs
    output logic reset_n_o,
    output logic power_fail_out_n_o,
    output logic ram_on_backup_o
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    sbr_sync_if sif ();
    logic mr_hi;
    logic pf_hi;

    // Comparators pass two flops before use
    sbr_sync #(.INIT(1'b1)) u_sync_sup (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .d_i(supply_low_i),
        .q_o(sif.supply_low)
    );
    sbr_sync #(.INIT(1'b0)) u_sync_bat (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .d_i(batt_above_i),
        .q_o(sif.batt_above)
    );
    // Power-fail input is high when above the reference
    sbr_sync #(.INIT(1'b0)) u_sync_pf (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .d_i(power_fail_in_i),
        .q_o(pf_hi)
    );
    // Floating manual reset reads high; inactive after reset
    sbr_sync #(.INIT(1'b1)) u_sync_mr (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .d_i(manual_reset_n_i),
        .q_o(mr_hi)
    );
    assign sif.pf_low = ~pf_hi;
    assign sif.mr_low = ~mr_hi;

    // ****************************************
    // Battery switchover
    // ****************************************
    // The comparator carries the 20 mV/40 mV hysteresis in the analog domain
    logic backup_q;
    logic backup_d;
    logic ram_bat_q;
    logic ram_bat_d;

    // Backup only below threshold with battery higher
    assign backup_d = sif.supply_low & sif.batt_above;
    // Above threshold the main supply always feeds the RAM
    assign ram_bat_d = backup_d;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            backup_q <= BACKUP_RESET;
            ram_bat_q <= BACKUP_RESET;
        end else begin
            backup_q <= backup_d;
            ram_bat_q <= ram_bat_d;
        end
    end

    assign ram_on_backup_o = ram_bat_q;

    // ****************************************
    // Reset sequencer
    // ****************************************
    sbr_state_t state_q;
    sbr_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic hold_req;
    logic cnt_done;
    logic rst_q;
    logic rst_d;

    // Manual reset is ignored in backup mode, supply low still holds
    assign hold_req = sif.supply_low | (sif.mr_low & ~backup_q);
    assign cnt_done = (cnt_q == CNT_W'(PULSE_CYC - 1));

    // Holding restarts the timer; release counts one full interval
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            SBR_HOLD: begin
                cnt_d = '0;
                if (!hold_req) begin
                    state_d = SBR_TIME;
                end
            end
            SBR_TIME: begin
                if (hold_req) begin
                    state_d = SBR_HOLD;
                    cnt_d = '0;
                end else if (cnt_done) begin
                    state_d = SBR_RUN;
                end else begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            SBR_RUN: begin
                cnt_d = '0;
                if (hold_req) begin
                    state_d = SBR_HOLD;
                end
            end
            default: begin
                state_d = SBR_HOLD;
                cnt_d = '0;
            end
        endcase
    end

    // Reset drops on the edge after the hold request is seen
    assign rst_d = (state_d == SBR_RUN) & ~hold_req;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= SBR_HOLD;
            cnt_q <= '0;
            rst_q <= RST_OUT_RESET;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            rst_q <= rst_d;
        end
    end

    // Reset output is driven low from reset onward, never left floating
    assign reset_n_o = rst_q;

    // ****************************************
    // Power-fail output
    // ****************************************
    logic pfo_q;
    logic pfo_d;

    // Comparator disabled and output low in backup mode
    assign pfo_d = ~sif.pf_low & ~backup_d;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pfo_q <= PFO_RESET;
        end else begin
            pfo_q <= pfo_d;
        end
    end

    assign power_fail_out_n_o = pfo_q;

    // ****************************************
    // Checks
    // ****************************************
    logic [CNT_W-1:0] low_run_q;

    // Cycles spent in reset since the last hold request
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            low_run_q <= '0;
        end else if (hold_req) begin
            low_run_q <= '0;
        end else if (!reset_n_o) begin
            low_run_q <= low_run_q + CNT_W'(1);
        end
    end

    // Shortest accepted pulse, scaled from the chosen interval
    // The product stays inside 32 bits even for the full 200 ms count
    localparam int unsigned MIN_CYC = PULSE_CYC * RST_MIN_MS / RST_PULSE_MS;

    // Manual line back high while the supply is good
    sequence mr_release_s;
        $rose(mr_hi) ##0 !sif.supply_low;
    endsequence

    // Supply back above threshold with the manual line idle
    sequence supply_back_s;
        $fell(sif.supply_low) ##0 !sif.mr_low;
    endsequence

    // Reset held through the first cycles of a new interval
    sequence held_low_s;
        !reset_n_o [*8];
    endsequence

    // Supply and manual requests pull reset low on the next edge
    reset_on_low_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        sif.supply_low |=> !reset_n_o
    ) else $error("reset high with supply low");
    manual_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (sif.mr_low && !backup_q) |=> !reset_n_o
    ) else $error("manual reset missed");

    // The SBR_HOLD cycle after the request ends adds one cycle to the counted interval
    release_time_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        $rose(reset_n_o) |-> low_run_q == CNT_W'(PULSE_CYC + 1)
    ) else $error("reset released at wrong time");
    min_pulse_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        $rose(reset_n_o) |-> low_run_q >= CNT_W'(MIN_CYC)
    ) else $error("reset pulse under minimum");
    supply_back_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        supply_back_s |=> held_low_s
    ) else $error("supply release too early");
    manual_rel_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        mr_release_s |=> held_low_s
    ) else $error("manual release too early");
    stay_high_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (reset_n_o && !hold_req) |=> reset_n_o
    ) else $error("reset dropped without request");

    // Timer restarts and never runs past its end count
    restart_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        hold_req |=> cnt_q == '0
    ) else $error("timer not restarted");
    cnt_bound_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        cnt_q <= CNT_W'(PULSE_CYC - 1)
    ) else $error("timer past end count");
    state_valid_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        $onehot(state_q)
    ) else $error("sequencer state not one-hot");

    // Power-fail output in both directions and in backup
    pfo_follow_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (!backup_d && !sif.pf_low) |=> power_fail_out_n_o
    ) else $error("power-fail output wrong");
    pfo_low_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        sif.pf_low |=> !power_fail_out_n_o
    ) else $error("power-fail output missed");
    pfo_backup_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        backup_d |=> !power_fail_out_n_o
    ) else $error("power-fail high in backup");

    // RAM supply switch and the hold in backup
    main_feed_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        !sif.supply_low |=> !ram_on_backup_o
    ) else $error("backup above threshold");
    switch_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (sif.supply_low && sif.batt_above) |=> ram_on_backup_o
    ) else $error("no switch to battery");
    switch_back_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (sif.supply_low && !sif.batt_above) |=> !ram_on_backup_o
    ) else $error("no switch back to main");
    backup_hold_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        backup_q |-> !reset_n_o
    ) else $error("reset high in backup");

endmodule // sbr_supervisor

`default_nettype wire

// >>> sbr_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Processor and pushbutton at the far side
// ****************************************
module sbr_cpu_model (
    // Clock and processor reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Button and sense level from the bench
    input wire logic press_i,
    input wire logic pf_level_i,
    // Lines into the supervisor
    output logic manual_reset_n_o,
    output logic power_fail_in_o,
    // Cycles run since the last reset
    output logic [7:0] run_cnt_o
);
    logic [7:0] run_cnt_q;

    // Button shorts to ground; a released line returns to its pull-up level
    assign manual_reset_n_o = press_i ? 1'b0 : 1'b1;
    // Sense input always driven by a divider, never left open
    assign power_fail_in_o = pf_level_i;
    // Processor only runs while its reset is released
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            run_cnt_q <= 8'h00;
        end else begin
            run_cnt_q <= run_cnt_q + 8'h01;
        end
    end
    assign run_cnt_o = run_cnt_q;
endmodule // sbr_cpu_model

`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // Short pulse so the run stays brief
    localparam int unsigned P = 20;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic supply_low_i = 1'b0;
    logic batt_above_i = 1'b0;
    logic press = 1'b0;
    logic pf_level = 1'b1;
    wire manual_reset_n_i;
    wire power_fail_in_i;
    wire reset_n_o;
    wire power_fail_out_n_o;
    wire ram_on_backup_o;
    wire [7:0] run_cnt;
    int error_cnt = 0;
    int checks = 0;

    // Clock, 20 ns period
    always #10 ref_clk_i = ~ref_clk_i;

    sbr_supervisor #(.PULSE_CYC(P)) u_sbr_supervisor (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .supply_low_i(supply_low_i),
        .batt_above_i(batt_above_i),
        .power_fail_in_i(power_fail_in_i),
        .manual_reset_n_i(manual_reset_n_i),
        .reset_n_o(reset_n_o),
        .power_fail_out_n_o(power_fail_out_n_o),
        .ram_on_backup_o(ram_on_backup_o)
    );

    sbr_cpu_model u_sbr_cpu_model (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_o),
        .press_i(press),
        .pf_level_i(pf_level),
        .manual_reset_n_o(manual_reset_n_i),
        .power_fail_in_o(power_fail_in_i),
        .run_cnt_o(run_cnt)
    );

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic seen, input logic exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // Inputs change and outputs are sampled at the falling edge
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    task automatic give_verdict();
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_power_up();
        cyc(P - 4);
        chk(reset_n_o, 1'b0);
        cyc(12);
        chk(reset_n_o, 1'b1);
        chk(ram_on_backup_o, 1'b0);
        chk(run_cnt != 8'h00, 1'b1);
    endtask

    // Brownout, then a second dip in the middle of the pulse
    task automatic t_brownout();
        supply_low_i = 1'b1;
        cyc(1);
        chk(reset_n_o, 1'b1);
        cyc(3);
        chk(reset_n_o, 1'b0);
        cyc(50);
        chk(reset_n_o, 1'b0);
        chk(ram_on_backup_o, 1'b0);
        supply_low_i = 1'b0;
        cyc(P / 2);
        supply_low_i = 1'b1;
        cyc(4);
        supply_low_i = 1'b0;
        cyc(P - 4);
        chk(reset_n_o, 1'b0);
        cyc(12);
        chk(reset_n_o, 1'b1);
    endtask

    task automatic t_manual();
        press = 1'b1;
        cyc(4);
        chk(reset_n_o, 1'b0);
        cyc(30);
        press = 1'b0;
        cyc(P - 4);
        chk(reset_n_o, 1'b0);
        cyc(12);
        chk(reset_n_o, 1'b1);
    endtask

    task automatic t_pfail();
        pf_level = 1'b0;
        cyc(1);
        chk(power_fail_out_n_o, 1'b1);
        cyc(3);
        chk(power_fail_out_n_o, 1'b0);
        pf_level = 1'b1;
        cyc(4);
        chk(power_fail_out_n_o, 1'b1);
    endtask

    // Backup entry, switch back below threshold, then recovery
    task automatic t_backup();
        supply_low_i = 1'b1;
        batt_above_i = 1'b1;
        cyc(4);
        chk(ram_on_backup_o, 1'b1);
        chk(power_fail_out_n_o, 1'b0);
        press = 1'b1;
        cyc(4);
        chk(reset_n_o, 1'b0);
        press = 1'b0;
        batt_above_i = 1'b0;
        cyc(4);
        chk(ram_on_backup_o, 1'b0);
        batt_above_i = 1'b1;
        cyc(4);
        supply_low_i = 1'b0;
        cyc(4);
        chk(ram_on_backup_o, 1'b0);
        chk(power_fail_out_n_o, 1'b1);
        cyc(P - 8);
        chk(reset_n_o, 1'b0);
        cyc(12);
        chk(reset_n_o, 1'b1);
    endtask

    // Mid-run reset: processor held, then a fresh power-up interval
    task automatic t_reset();
        nrst_i = 1'b0;
        cyc(2);
        chk(reset_n_o, 1'b0);
        chk(run_cnt == 8'h00, 1'b1);
        chk(ram_on_backup_o, 1'b0);
        nrst_i = 1'b1;
        cyc(P - 4);
        chk(reset_n_o, 1'b0);
        cyc(12);
        chk(reset_n_o, 1'b1);
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        cyc(10);
        nrst_i = 1'b1;
        t_power_up();
        t_brownout();
        t_manual();
        t_pfail();
        t_backup();
        t_reset();
        give_verdict();
    end

    // About 280 cycles are needed; allow about fourteen times that
    initial begin
        #80000;
        error_cnt++;
        give_verdict();
    end
endmodule // tb_top

`default_nettype wire
